// file: src/dsrs_supervisor.sv
/*
 Dual supply reset supervisor logic: select decode, comparator filtering,
 restartable release delay and complementary open-drain reset outputs.
 Assumes under-threshold flags and pin states arrive asynchronously and are
 synchronised here; analog comparison happens outside using SEL_OUT.
 Reset is synchronous; the synchroniser flops have no reset and keep sampling while it is held.
*/
`include "dsrs_map.svh"

module dsrs_supervisor #(
   parameter int unsigned ADJUSTABLE = 0,
   parameter int unsigned CAP_NF     = 22,
   parameter int unsigned FIXED_CYC  = `DSRS_DELAY_CYC,
   parameter int unsigned FILT_CYC   = `DSRS_FILT_CYC
) (
   input  wire logic             CLOCK,
   input  wire logic             SRST,
   input  wire logic             POWER_UP_1V,
   input  wire logic             PROGRAM_DONE,
   input  wire logic [1:0]       THRESHOLD_SELECT_A,
   input  wire logic [1:0]       THRESHOLD_SELECT_B,
   input  wire logic [1:0]       TOLERANCE_SELECT,
   input  wire logic             UNDER_ONE,
   input  wire logic             UNDER_TWO,
   output dsrs_pkg::dsrs_sel_t   SEL_OUT,
   output logic                  RESET_N_O,
   output logic                  RESET_N_OE,
   output logic                  RESET_O,
   output logic                  RESET_OE
);

   ////////////////////////////////////////////////////////////////////////
   // Delay terminal count
   localparam longint unsigned ADJ_RAW =
      64'(CAP_NF) * 64'(`DSRS_MS_PER_NF) * 64'(`DSRS_CLK_KHZ);
   localparam longint unsigned ADJ_CYC =
      (ADJ_RAW < 64'(`DSRS_MIN_DELAY_CYC)) ? 64'(`DSRS_MIN_DELAY_CYC) : ADJ_RAW;
   localparam longint unsigned TERM_CYC =
      (ADJUSTABLE != 0) ? ADJ_CYC : 64'(FIXED_CYC);
   localparam int CW = $clog2(TERM_CYC + 1);
   localparam int FW = $clog2(FILT_CYC + 1);
   localparam logic [CW-1:0] TERM = CW'(TERM_CYC - 1);
   localparam logic [FW-1:0] FTERM = FW'(FILT_CYC - 1);

   ////////////////////////////////////////////////////////////////////////
   // Decode functions
   function automatic logic [17:0] pair_decode(input logic [1:0] a, input logic [1:0] b);
      logic [17:0] r;
      r = {`DSRS_MV_330, `DSRS_MV_120};
      unique case ({a, b})
         {`DSRS_PIN_HIGH, `DSRS_PIN_HIGH}: r = {`DSRS_MV_500, `DSRS_MV_330};
         {`DSRS_PIN_OPEN, `DSRS_PIN_LOW }: r = {`DSRS_MV_330, `DSRS_MV_250};
         {`DSRS_PIN_HIGH, `DSRS_PIN_OPEN}: r = {`DSRS_MV_330, `DSRS_MV_180};
         {`DSRS_PIN_OPEN, `DSRS_PIN_HIGH}: r = {`DSRS_MV_330, `DSRS_MV_150};
         {`DSRS_PIN_LOW,  `DSRS_PIN_LOW }: r = {`DSRS_MV_250, `DSRS_MV_180};
         {`DSRS_PIN_LOW,  `DSRS_PIN_OPEN}: r = {`DSRS_MV_250, `DSRS_MV_150};
         {`DSRS_PIN_LOW,  `DSRS_PIN_HIGH}: r = {`DSRS_MV_250, `DSRS_MV_120};
         {`DSRS_PIN_HIGH, `DSRS_PIN_LOW }: r = {`DSRS_MV_250, `DSRS_MV_100};
         default:                          r = {`DSRS_MV_330, `DSRS_MV_120};
      endcase
      return r;
   endfunction : pair_decode

   // Open or an unused code both fall back to the middle margin
   function automatic logic [6:0] margin_decode(input logic [1:0] t);
      logic [6:0] r;
      r = `DSRS_MARGIN_75;
      unique case (t)
         `DSRS_PIN_HIGH: r = `DSRS_MARGIN_50;
         `DSRS_PIN_LOW:  r = `DSRS_MARGIN_100;
         default:        r = `DSRS_MARGIN_75;
      endcase
      return r;
   endfunction : margin_decode

   ////////////////////////////////////////////////////////////////////////
   // Two-stage synchronisers for all outside inputs except SRST
   // Select pins are static once powered, so per-bit syncing is safe
   localparam int SW = 10;
   logic [SW-1:0] raw_in;
   logic [SW-1:0] meta_q;
   logic [SW-1:0] sync_q;
   assign raw_in = {POWER_UP_1V, PROGRAM_DONE, THRESHOLD_SELECT_A,
                    THRESHOLD_SELECT_B, TOLERANCE_SELECT, UNDER_ONE, UNDER_TWO};

   always_ff @(posedge CLOCK)
   begin
      meta_q <= raw_in;
      sync_q <= meta_q;
   end

   wire       pwr_s  = sync_q[9];
   wire       prog_s = sync_q[8];
   wire [1:0] sa_s   = sync_q[7:6];
   wire [1:0] sb_s   = sync_q[5:4];
   wire [1:0] margin_s = sync_q[3:2];
   wire [1:0] under_s = sync_q[1:0];

   ////////////////////////////////////////////////////////////////////////
   // Selection latched once programming is complete
   dsrs_pkg::dsrs_sel_t sel_q;
   dsrs_pkg::dsrs_sel_t sel_d;
   logic                latched_q;
   assign sel_d = {pair_decode(sa_s, sb_s), margin_decode(margin_s)};

   always_ff @(posedge CLOCK)
   begin
      if (SRST || !pwr_s)
      begin
         sel_q     <= '0;
         latched_q <= 1'b0;
      end
      else if (!latched_q)
      begin
         sel_q     <= sel_d;
         latched_q <= prog_s;
      end
   end
   assign SEL_OUT = sel_q;

   ////////////////////////////////////////////////////////////////////////
   // Per-input persistence filters, both directions
   wire [1:0] good_flags;
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_filt
         logic [FW-1:0] cnt_q;
         logic          good_q;
         wire           differ = (!under_s[g]) != good_q;
         // Flag flips only after FILT_CYC cycles of steady disagreement
         always_ff @(posedge CLOCK)
         begin
            if (SRST || !latched_q)
            begin
               cnt_q  <= '0;
               good_q <= 1'b0;
            end
            else if (!differ)
               cnt_q <= '0;
            else if (cnt_q == FTERM)
            begin
               cnt_q  <= '0;
               good_q <= !under_s[g];
            end
            else
               cnt_q <= cnt_q + 1'b1;
         end
         // Each flag bit has a single driver
         assign good_flags[g] = good_q;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Release sequencer with restartable delay counter
   dsrs_pkg::dsrs_state_t state_q;
   dsrs_pkg::dsrs_state_t state_d;
   logic [CW-1:0]         dly_q;
   logic [CW-1:0]         dly_d;
   wire                   all_good = &good_flags;
   wire                   dly_end  = (dly_q == TERM);
   wire                   counting = (state_d == dsrs_pkg::DSRS_COUNT) &&
                                     (state_q == dsrs_pkg::DSRS_COUNT);

   // Any exit from COUNT clears the delay, so a dip restarts it from zero
   assign dly_d = counting ? dly_q + 1'b1 : '0;

   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         dsrs_pkg::DSRS_OFF:   if (pwr_s) state_d = dsrs_pkg::DSRS_HOLD;
         dsrs_pkg::DSRS_HOLD:  if (all_good) state_d = dsrs_pkg::DSRS_COUNT;
         dsrs_pkg::DSRS_COUNT:
            if (!all_good) state_d = dsrs_pkg::DSRS_HOLD;
            else if (dly_end) state_d = dsrs_pkg::DSRS_RUN;
         dsrs_pkg::DSRS_RUN:   if (!all_good) state_d = dsrs_pkg::DSRS_HOLD;
      endcase
      if (!pwr_s)
         state_d = dsrs_pkg::DSRS_OFF;
   end

   always_ff @(posedge CLOCK)
   begin
      if (SRST)
      begin
         state_q <= dsrs_pkg::DSRS_OFF;
         dly_q   <= '0;
      end
      else
      begin
         state_q <= state_d;
         dly_q   <= dly_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Complementary open-drain outputs from flip-flops
   logic rst_n_q;
   logic rst_q;
   wire  rst_n_d = (state_d == dsrs_pkg::DSRS_RUN);
   wire  rst_d   = !rst_n_d;
   always_ff @(posedge CLOCK)
   begin
      if (SRST)
      begin
         rst_n_q <= 1'b0;
         rst_q   <= 1'b1;
      end
      else
      begin
         rst_n_q <= rst_n_d;
         rst_q   <= rst_d;
      end
   end

   assign RESET_N_O  = 1'b0;
   assign RESET_N_OE = !rst_n_q;
   assign RESET_O    = 1'b0;
   assign RESET_OE   = !rst_q;

endmodule : dsrs_supervisor

// file: shared/dsrs_map.svh
/*
 Constants for the dual supply reset supervisor: pin encodings, threshold
 codes, tolerance codes and timing counts.
 Assumes a 25 MHz clock and is included by the design.
*/
`ifndef DSRS_MAP_SVH
`define DSRS_MAP_SVH

// Three-state pin codes
`define DSRS_PIN_LOW          2'h0
`define DSRS_PIN_OPEN         2'h1
`define DSRS_PIN_HIGH         2'h2

// Nominal voltages in tens of millivolts
`define DSRS_MV_500           9'h1F4
`define DSRS_MV_330           9'h14A
`define DSRS_MV_250           9'h0FA
`define DSRS_MV_180           9'h0B4
`define DSRS_MV_150           9'h096
`define DSRS_MV_120           9'h078
`define DSRS_MV_100           9'h064

// Tolerance in tenths of a percent
`define DSRS_MARGIN_50        7'h32
`define DSRS_MARGIN_75        7'h4B
`define DSRS_MARGIN_100       7'h64

// Timing
`define DSRS_CLK_KHZ          25000
`define DSRS_DELAY_MS         200
`define DSRS_DELAY_CYC        (`DSRS_DELAY_MS * `DSRS_CLK_KHZ)
`define DSRS_MS_PER_NF        9
`define DSRS_MIN_DELAY_US     200
`define DSRS_MIN_DELAY_CYC    (`DSRS_MIN_DELAY_US * `DSRS_CLK_KHZ / 1000)
`define DSRS_FILT_US          150
`define DSRS_FILT_CYC         (`DSRS_FILT_US * `DSRS_CLK_KHZ / 1000)

`endif

// file: shared/dsrs_pkg.sv
/*
 Types for the dual supply reset supervisor.
 Assumes dsrs_map.svh is reachable on the include path.
*/
package dsrs_pkg;

   // Decoded threshold selection
   typedef struct packed {
      logic [8:0] nom_one;
      logic [8:0] nom_two;
      logic [6:0] margin;
   } dsrs_sel_t;

   // Reset sequencer states
   typedef enum logic [1:0] {
      DSRS_OFF,
      DSRS_HOLD,
      DSRS_COUNT,
      DSRS_RUN
   } dsrs_state_t;

endpackage : dsrs_pkg

// file: dv/dsrs_supervisor_properties.sv
/* Checker for the reset supervisor outputs.
 Bound to dsrs_supervisor; expects FILT_CYC of 4 in simulation. */
module dsrs_props_chk #(
   parameter int unsigned FIXED_CYC = 20,
   parameter int unsigned FILT_CYC  = 4
) (
   input wire logic                CLOCK,
   input wire logic                SRST,
   input wire logic                POWER_UP_1V,
   input wire logic                PROGRAM_DONE,
   input wire logic                UNDER_ONE,
   input wire logic                UNDER_TWO,
   input wire dsrs_pkg::dsrs_sel_t SEL_OUT,
   input wire logic                RESET_N_O,
   input wire logic                RESET_N_OE,
   input wire logic                RESET_O,
   input wire logic                RESET_OE
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (SRST);
   ////////////////////////////////////////////////////////////////
   // Cycles since supplies last looked bad
   logic [15:0] ok_q;
   logic [15:0] ok_d;
   wire         bad = SRST | UNDER_ONE | UNDER_TWO | !POWER_UP_1V | !PROGRAM_DONE;
   assign ok_d = bad ? 16'h0 : ((&ok_q) ? ok_q : ok_q + 16'h1);
   always_ff @(posedge CLOCK) ok_q <= ok_d;
   ////////////////////////////////////////////////////////////////
   // Output relations
   sequence dip_one_s;
      UNDER_ONE [*8];
   endsequence
   compl_out_a: assert property (RESET_OE == !RESET_N_OE)
      else $error("reset outputs not complementary");
   drain_low_a: assert property (!RESET_N_O && !RESET_O)
      else $error("open drain data not low");
   dip_one_a: assert property (dip_one_s |=> RESET_N_OE)
      else $error("low supply one did not assert reset");
   dip_two_a: assert property (UNDER_TWO [*8] |=> RESET_N_OE)
      else $error("low supply two did not assert reset");
   power_low_a: assert property (!POWER_UP_1V [*3] |=> RESET_N_OE)
      else $error("reset not asserted at low power");
   early_rel_a: assert property ($fell(RESET_N_OE) |-> ok_q >= FIXED_CYC + FILT_CYC)
      else $error("reset released before delay");
   late_rel_a: assert property (ok_q == FIXED_CYC + FILT_CYC + 16 |-> !RESET_N_OE)
      else $error("reset not released after delay");
   sel_hold_a: assert property (!RESET_N_OE && $past(!RESET_N_OE) |-> $stable(SEL_OUT))
      else $error("selection moved after latch");
endmodule : dsrs_props_chk

bind dsrs_supervisor dsrs_props_chk #(.FIXED_CYC(FIXED_CYC), .FILT_CYC(FILT_CYC))
   dsrs_props_chk_i (.*);

// file: dv/dsrs_reset_sink.sv
/* Logic receiving both reset lines.
 Assumes weak pull-ups on both open drain lines. */
module dsrs_reset_sink (
   input  wire logic rst_n_oe,
   input  wire logic rst_oe,
   output logic      rst_n_line,
   output logic      rst_line
);
   timeunit 1ns;
   timeprecision 1ns;
   // Pull-up wins unless the pin pulls low
   assign rst_n_line = rst_n_oe ? 1'b0 : 1'b1;
   assign rst_line   = rst_oe ? 1'b0 : 1'b1;
endmodule : dsrs_reset_sink

// file: dv/dsrs_supervisor_tb_top.sv
/* Self-checking bench for the reset supervisor.
 Assumes short delay counts set here. */
module dsrs_supervisor_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int FX = 20;
   localparam int FL = 4;
   localparam logic [1:0] SA[9] = '{2'h2,2'h1,2'h2,2'h1,2'h1,2'h0,2'h0,2'h0,2'h2};
   localparam logic [1:0] SB[9] = '{2'h2,2'h0,2'h1,2'h2,2'h1,2'h0,2'h1,2'h2,2'h0};
   localparam logic [8:0] NOM_ONE[9] = '{9'h1F4,9'h14A,9'h14A,9'h14A,9'h14A,9'h0FA,9'h0FA,
                                         9'h0FA,9'h0FA};
   localparam logic [8:0] NOM_TWO[9] = '{9'h14A,9'h0FA,9'h0B4,9'h096,9'h078,9'h0B4,9'h096,
                                         9'h078,9'h064};
   localparam logic [6:0] TL[3] = '{7'h64,7'h4B,7'h32};
   logic clk = 0, srst = 1, pwr = 0, pdone = 0, u1 = 0, u2 = 0;
   logic [1:0] sa = 2'h0, sb = 2'h0, margin = 2'h0;
   dsrs_pkg::dsrs_sel_t sel;
   logic rno, rnoe, ro, roe, line_n, line;
   int bad_count = 0;
   int n_tests = 0;
   int n;
   initial forever #20 clk = ~clk;
   dsrs_supervisor #(.FIXED_CYC(FX), .FILT_CYC(FL)) dsrs_supervisor_i (.CLOCK(clk),
      .SRST(srst), .POWER_UP_1V(pwr), .PROGRAM_DONE(pdone), .THRESHOLD_SELECT_A(sa),
      .THRESHOLD_SELECT_B(sb), .TOLERANCE_SELECT(margin), .UNDER_ONE(u1), .UNDER_TWO(u2),
      .SEL_OUT(sel), .RESET_N_O(rno), .RESET_N_OE(rnoe), .RESET_O(ro), .RESET_OE(roe));
   dsrs_reset_sink dsrs_reset_sink_i (.rst_n_oe(rnoe), .rst_oe(roe),
      .rst_n_line(line_n), .rst_line(line));
   ////////////////////////////////////////////////////////////////
   // Helpers
   task chk(input string nm, input logic [24:0] exp, input logic [24:0] got);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task power_up(input logic [1:0] a, input logic [1:0] b, input logic [1:0] t);
      @(posedge clk);
      pwr <= 1'b0;
      pdone <= 1'b0;
      sa <= a;
      sb <= b;
      margin <= t;
      repeat (4) @(posedge clk);
      pwr <= 1'b1;
      repeat (4) @(posedge clk);
      pdone <= 1'b1;
   endtask : power_up
   task wait_rel();
      n = 0;
      while (line_n !== 1'b1 && n < 200)
      begin
         @(negedge clk);
         n++;
      end
   endtask : wait_rel
   ////////////////////////////////////////////////////////////////
   // Scenarios
   task t_decode();
      for (int i = 0; i < 9; i++)
      begin
         power_up(SA[i], SB[i], 2'(i % 3));
         repeat (8) @(negedge clk);
         chk("selection", {NOM_ONE[i], NOM_TWO[i], TL[i % 3]}, sel);
      end
      @(posedge clk);
      sa <= 2'h0;
      margin <= 2'h0;
      repeat (6) @(negedge clk);
      chk("latched selection", {NOM_ONE[8], NOM_TWO[8], TL[2]}, sel);
   endtask : t_decode
   task t_release();
      power_up(2'h2, 2'h2, 2'h2);
      wait_rel();
      chk("release delay", 25'h1, 25'(n >= FX + FL && n < FX + FL + 16));
      chk("active high line", 25'h0, 25'(line));
   endtask : t_release
   task t_dip();
      @(posedge clk);
      u1 <= 1'b1;
      repeat (2) @(posedge clk);
      u1 <= 1'b0;
      repeat (10) @(negedge clk);
      chk("glitch ignored", 25'h1, 25'(line_n));
      @(posedge clk);
      u2 <= 1'b1;
      repeat (9) @(negedge clk);
      chk("drop asserts", 25'h0, 25'(line_n));
      @(posedge clk);
      u2 <= 1'b0;
      repeat (FL + FX / 2) @(posedge clk);
      u1 <= 1'b1;
      repeat (9) @(posedge clk);
      u1 <= 1'b0;
      wait_rel();
      chk("restarted delay", 25'h1, 25'(n >= FX + FL && n < 200));
   endtask : t_dip
   task t_power();
      @(posedge clk);
      pwr <= 1'b0;
      repeat (4) @(negedge clk);
      chk("power low reset", 25'h0, 25'(line_n));
   endtask : t_power
   ////////////////////////////////////////////////////////////////
   // Closing and sequence
   task end_of_test();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_of_test
   initial
   begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      t_decode();
      t_release();
      t_dip();
      t_power();
      end_of_test();
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      end_of_test();
   end
endmodule : dsrs_supervisor_tb_top
